// ==== design/ssp_map.svh ====
// Register map, field positions, reset values and timing constants of the serial port
// Contract
// - Phase bit picks first or second sampling edge
// - Polarity bit sets serial clock idle level
// - Master and slave share phase and polarity
// - Master samples input one clock before sampling edge, same clock when div is 0
// - Master clock is system clock over 2(div+1)
// - Divider ignored in slave mode
// - Busy flag high during any transfer
// - Master enable selects master or slave role
// - Slave-selected bit follows deglitched select low
// - Raw select bit shows undeglitched pin level
// - Shift-empty flag slave only, master reads one
// - Receive-empty flag slave only, master reads one
// - Transfer end sets done flag, software clears
// - Data write during transfer sets collision flag
// - Select low in multi-master master sets fault
// - Slave byte into full buffer sets overrun
// - Select mode field: unused, input, or output
// - Transmit-empty clears on write, sets on load
// - Data write loads buffer, read returns receive
// - Mode fault clears master and port enable
// - Colliding data write is discarded
// - Select falling edge resets slave edge counter in select-input mode
// - Bytes travel most significant bit first
`ifndef SSP_MAP_SVH
`define SSP_MAP_SVH
// ---------------------------------------------------------------
// Offsets
// ---------------------------------------------------------------
`define SSP_ADDR_DATA 8'h9B
`define SSP_ADDR_DIV 8'h9D
`define SSP_ADDR_CTRL 8'hF8
`define SSP_ADDR_CFG 8'h9A
// ---------------------------------------------------------------
// Configuration fields
// ---------------------------------------------------------------
`define SSP_CFG_BUSY 7
`define SSP_CFG_MASTER_ENABLE 6
`define SSP_CFG_PHASE 5
`define SSP_CFG_POL 4
`define SSP_CFG_SLAVE_SELECTED 3
`define SSP_CFG_RAWSEL 2
`define SSP_CFG_SHIFT_REG_EMPTY 1
`define SSP_CFG_RX_BUFFER_EMPTY 0
// ---------------------------------------------------------------
// Control fields
// ---------------------------------------------------------------
`define SSP_CTL_DONE 7
`define SSP_CTL_WRITE_COLLISION_FLAG 6
`define SSP_CTL_MODE_FAULT_FLAG 5
`define SSP_CTL_OVRN 4
`define SSP_CTL_MODE_HI 3
`define SSP_CTL_MODE_LO 2
`define SSP_CTL_TX_BUFFER_EMPTY 1
`define SSP_CTL_EN 0
// ---------------------------------------------------------------
// Reset values and counts
// ---------------------------------------------------------------
`define SSP_RST_DATA 8'h00
`define SSP_RST_DIV 8'h00
`define SSP_RST_CTRL 8'h06
`define SSP_RST_CFG 8'h07
`define SSP_BITS_PER_BYTE 4'h8
`define SSP_EDGES_PER_BYTE 5'h10
`endif

// ==== design/ssp_pkg.sv ====
// Types shared by the serial port files
package ssp_pkg;
  typedef logic [7:0] ssp_byte_t;
  typedef enum logic [1:0] {SSP_SEL_3WIRE, SSP_SEL_INPUT, SSP_SEL_OUT_LO, SSP_SEL_OUT_HI}
    ssp_sel_mode_t;
  typedef enum logic [1:0] {SSP_IDLE, SSP_HALF_A, SSP_HALF_B} ssp_state_t;
endpackage : ssp_pkg

// ==== design/ssp_sync3.sv ====
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module ssp_sync3 (
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic RST_VAL,
  input wire logic PIN,
  output logic LEVEL
);
  logic s1;
  logic s2;
  logic s3;
  // Change is taken once second and third stages agree
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      LEVEL <= 1'b0;
    end else begin
      s1 <= PIN;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        LEVEL <= s3;
      end
    end
  end
  wire unused_rst_val = RST_VAL;
endmodule : ssp_sync3

// ==== design/ssp_port.sv ====
// Byte-wide synchronous serial port, master or slave, with its four registers
`timescale 1ns/1ps
`include "ssp_map.svh"
module ssp_port (
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic [7:0] ADDR,
  input wire logic WR,
  input wire logic RD,
  input wire ssp_pkg::ssp_byte_t WDATA,
  output ssp_pkg::ssp_byte_t RDATA,
  output logic IRQ,
  output logic SCK_O,
  output logic SCK_OE_N,
  input wire logic SCK_I,
  output logic MOSI_O,
  output logic MOSI_OE_N,
  input wire logic MOSI_I,
  output logic MISO_O,
  output logic MISO_OE_N,
  input wire logic MISO_I,
  output logic NSS_O,
  output logic NSS_OE_N,
  input wire logic NSS_I
);
  import ssp_pkg::*;

  // ---------------------------------------------------------------
  // Register state
  // ---------------------------------------------------------------
  ssp_byte_t div;
  ssp_byte_t tx_buf;
  ssp_byte_t rx_buf;
  ssp_byte_t shreg;
  logic master_enable, phase, pol, en;
  logic [1:0] sel_mode;
  logic done_f, write_collision_flag_f, mode_fault_flag_f, ovrn_f;
  logic tx_empty, rx_unread, sh_loaded;
  ssp_state_t state;
  ssp_byte_t cnt;
  logic [3:0] bits;
  logic [4:0] sedges;
  logic in_bit;
  logic sck_s, nss_s, mosi_s, sck_prev, nss_prev;
  logic nss_act;
  logic sck_r;

  ssp_sync3 u_sck (.CLK(CLK), .ARST_N(ARST_N), .RST_VAL(1'b0), .PIN(SCK_I), .LEVEL(sck_s));
  // Select is synchronised inverted so the flops reset to its idle (high) level
  ssp_sync3 u_nss (.CLK(CLK), .ARST_N(ARST_N), .RST_VAL(1'b1), .PIN(!NSS_I),
    .LEVEL(nss_act));
  assign nss_s = !nss_act;
  ssp_sync3 u_mosi (.CLK(CLK), .ARST_N(ARST_N), .RST_VAL(1'b0), .PIN(MOSI_I),
    .LEVEL(mosi_s));

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  wire wr_data = WR && (ADDR == `SSP_ADDR_DATA);
  wire wr_div = WR && (ADDR == `SSP_ADDR_DIV);
  wire wr_ctl = WR && (ADDR == `SSP_ADDR_CTRL);
  wire wr_cfg = WR && (ADDR == `SSP_ADDR_CFG);
  wire rd_data = RD && (ADDR == `SSP_ADDR_DATA);
  wire sel_input = (sel_mode == 2'b01);
  wire master = master_enable && en;
  wire nss_low = !nss_s;
  wire nss_fall = nss_prev && !nss_s;
  wire mode_fault_flag_evt = en && master_enable && sel_input && nss_low;
  // Slave is selected in select-input mode only when the line is low; 3-wire and output modes always
  wire slave_act = en && !master_enable && (!sel_input || nss_low);
  wire sck_edge = slave_act && (sck_s != sck_prev);
  // Leading edge leaves idle level; phase picks which edge samples
  wire lead_edge = sck_edge && (sck_s != pol);
  wire slave_sample = sck_edge && (lead_edge ^ phase);
  wire slave_shift = sck_edge && !(lead_edge ^ phase);
  wire busy = (state != SSP_IDLE) || (sedges != 5'h00);
  wire tick = (cnt == div);
  wire last_edge_s = sck_edge && (sedges == `SSP_EDGES_PER_BYTE - 5'h01);
  wire m_start = master && (state == SSP_IDLE) && !tx_empty;
  wire s_load = slave_act && !sh_loaded && !tx_empty && (sedges == 5'h00);
  wire collide = wr_data && (busy || !tx_empty);
  wire m_end = (state == SSP_HALF_B) && tick && (bits == `SSP_BITS_PER_BYTE - 4'h1);
  wire s_end = last_edge_s;
  wire xfer_end = m_end || s_end;
  wire ovrn_evt = s_end && rx_unread;
  // One clock before the sampling edge (on that clock when div is 0) the master samples input
  wire m_sample_pt = (cnt == div - 8'h01) || (div == 8'h00);
  wire m_samp_half = phase ? (state == SSP_HALF_B) : (state == SSP_HALF_A);
  wire m_sample = master && m_samp_half && m_sample_pt;
  wire shift_reg_empty = master ? 1'b1 : !(sh_loaded || busy);
  wire rx_buffer_empty = master ? 1'b1 : !rx_unread;
  wire [7:0] cfg_rd = {busy, master_enable, phase, pol, nss_low, NSS_I, shift_reg_empty, rx_buffer_empty};
  wire [7:0] ctl_rd = {done_f, write_collision_flag_f, mode_fault_flag_f, ovrn_f, sel_mode, tx_empty, en};
  wire [7:0] next_rdata = (ADDR == `SSP_ADDR_DATA) ? rx_buf :
                          (ADDR == `SSP_ADDR_DIV) ? div :
                          (ADDR == `SSP_ADDR_CTRL) ? ctl_rd :
                          (ADDR == `SSP_ADDR_CFG) ? cfg_rd : 8'h00;

  // ---------------------------------------------------------------
  // Configuration and control
  // ---------------------------------------------------------------
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      div <= `SSP_RST_DIV;
      {master_enable, phase, pol} <= 3'h0;
      sel_mode <= 2'b01;
      en <= 1'b0;
    end else begin
      if (wr_div) div <= WDATA;
      if (wr_cfg) begin
        master_enable <= WDATA[`SSP_CFG_MASTER_ENABLE];
        phase <= WDATA[`SSP_CFG_PHASE];
        pol <= WDATA[`SSP_CFG_POL];
      end
      if (wr_ctl) begin
        sel_mode <= WDATA[`SSP_CTL_MODE_HI:`SSP_CTL_MODE_LO];
        en <= WDATA[`SSP_CTL_EN];
      end
      if (mode_fault_flag_evt) begin
        master_enable <= 1'b0;
        en <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Sticky flags, hardware set wins over software clear
  // ---------------------------------------------------------------
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      {done_f, write_collision_flag_f, mode_fault_flag_f, ovrn_f} <= 4'h0;
    end else begin
      done_f <= xfer_end || (done_f && !(wr_ctl && !WDATA[`SSP_CTL_DONE]));
      write_collision_flag_f <= collide || (write_collision_flag_f && !(wr_ctl && !WDATA[`SSP_CTL_WRITE_COLLISION_FLAG]));
      mode_fault_flag_f <= mode_fault_flag_evt || (mode_fault_flag_f && !(wr_ctl && !WDATA[`SSP_CTL_MODE_FAULT_FLAG]));
      ovrn_f <= ovrn_evt || (ovrn_f && !(wr_ctl && !WDATA[`SSP_CTL_OVRN]));
    end
  end

  // ---------------------------------------------------------------
  // Buffers
  // ---------------------------------------------------------------
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      tx_buf <= `SSP_RST_DATA;
      tx_empty <= 1'b1;
      rx_buf <= `SSP_RST_DATA;
      rx_unread <= 1'b0;
    end else begin
      if (wr_data && !collide) begin
        tx_buf <= WDATA;
        tx_empty <= 1'b0;
      end else if (m_start || s_load) begin
        tx_empty <= 1'b1;
      end
      if (xfer_end && !ovrn_evt) begin
        // Last bit shifts on this same edge, so take it from its source
        rx_buf <= {shreg[6:0], (s_end && phase) ? mosi_s : in_bit};
        rx_unread <= !master;
      end else if (rd_data) begin
        rx_unread <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Master clock engine
  // ---------------------------------------------------------------
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state <= SSP_IDLE;
      cnt <= 8'h00;
      bits <= 4'h0;
      sck_r <= 1'b0;
    end else begin
      unique case (state)
        SSP_IDLE: begin
          cnt <= 8'h00;
          bits <= 4'h0;
          sck_r <= pol;
          if (m_start) state <= SSP_HALF_A;
        end
        SSP_HALF_A: begin
          cnt <= tick ? 8'h00 : cnt + 8'h01;
          if (!master) begin
            state <= SSP_IDLE;
          end else if (tick) begin
            sck_r <= !sck_r;
            state <= SSP_HALF_B;
          end
        end
        SSP_HALF_B: begin
          cnt <= tick ? 8'h00 : cnt + 8'h01;
          if (!master) begin
            state <= SSP_IDLE;
          end else if (tick) begin
            sck_r <= !sck_r;
            bits <= bits + 4'h1;
            state <= m_end ? SSP_IDLE : SSP_HALF_A;
          end
        end
        default: state <= SSP_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Shift register, MSB first in both directions
  // ---------------------------------------------------------------
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      shreg <= 8'h00;
      in_bit <= 1'b0;
      sh_loaded <= 1'b0;
      sedges <= 5'h00;
      sck_prev <= 1'b0;
      nss_prev <= 1'b1;
    end else begin
      sck_prev <= sck_s;
      nss_prev <= nss_s;
      if (m_start || s_load) begin
        shreg <= tx_buf;
        sh_loaded <= 1'b1;
      end else if (master) begin
        if (m_sample) in_bit <= MISO_I;
        // Phase 0 shifts on the half-B edge, phase 1 on the next half-A edge
        if (tick && ((state == SSP_HALF_B && !phase) || (state == SSP_HALF_A && phase &&
            bits != 4'h0))) begin
          shreg <= {shreg[6:0], in_bit};
        end
        if (m_end && phase) shreg <= {shreg[6:0], in_bit};
        if (m_end) sh_loaded <= 1'b0;
      end else begin
        if (slave_sample) in_bit <= mosi_s;
        if (slave_shift && sedges != 5'h00) shreg <= {shreg[6:0], in_bit};
        if (sck_edge) sh_loaded <= 1'b0;
        if (s_end && phase) shreg <= {shreg[6:0], mosi_s};
      end
      // Edge counter for byte boundary, cleared by select falling edge in select-input mode
      if (!en || master_enable || (sel_input && nss_fall) || s_end) begin
        sedges <= 5'h00;
      end else if (sck_edge) begin
        sedges <= sedges + 5'h01;
      end
    end
  end

  // ---------------------------------------------------------------
  // Pins and read data, all registered
  // ---------------------------------------------------------------
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      RDATA <= 8'h00;
      IRQ <= 1'b0;
      SCK_O <= 1'b0;
      SCK_OE_N <= 1'b1;
      MOSI_O <= 1'b0;
      MOSI_OE_N <= 1'b1;
      MISO_O <= 1'b0;
      MISO_OE_N <= 1'b1;
      NSS_O <= 1'b1;
      NSS_OE_N <= 1'b1;
    end else begin
      RDATA <= next_rdata;
      IRQ <= done_f || write_collision_flag_f || mode_fault_flag_f || ovrn_f;
      SCK_O <= master ? sck_r : pol;
      SCK_OE_N <= !master;
      MOSI_O <= shreg[7];
      MOSI_OE_N <= !master;
      MISO_O <= shreg[7];
      // 4-wire slave releases its output when not selected
      MISO_OE_N <= !slave_act;
      NSS_O <= sel_mode[0];
      NSS_OE_N <= !(en && sel_mode[1]);
    end
  end
endmodule : ssp_port

// ==== test/ssp_port_sva.sv ====
// Checker for the serial port register reads and pin behaviour
`timescale 1ns/1ps
module ssp_port_sva (
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic [7:0] ADDR,
  input wire logic WR,
  input wire ssp_pkg::ssp_byte_t WDATA,
  input wire ssp_pkg::ssp_byte_t RDATA,
  input wire logic IRQ,
  input wire logic SCK_O,
  input wire logic SCK_OE_N,
  input wire logic MOSI_OE_N,
  input wire logic NSS_O,
  input wire logic NSS_OE_N,
  input wire logic NSS_I
);
  import ssp_pkg::*;
  // Shadows snooped from writes; hardware clearing is not mirrored
  logic master_enable, pol, en, sck_q;
  logic [1:0] mode;
  logic [7:0] div;
  logic [8:0] half;
  wire ctl_wr = WR && ADDR == 8'hF8;
  wire sck_chg = SCK_O != sck_q;
  wire fault_cond = !NSS_I && master_enable && en && mode == 2'b01;
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      {master_enable, pol, en, mode, div} <= {3'h0, 2'h1, 8'h00};
      sck_q <= 1'b0;
      half <= 9'h000;
    end else begin
      if (WR && ADDR == 8'h9A) {master_enable, pol} <= {WDATA[6], WDATA[4]};
      if (ctl_wr) {mode, en} <= {WDATA[3:2], WDATA[0]};
      if (WR && ADDR == 8'h9D) div <= WDATA;
      sck_q <= SCK_O;
      // Saturates so an idle line never wraps to a short count
      half <= sck_chg ? 9'h001 : half + {8'h00, half != 9'h1FF};
    end
  end
  default clocking @(posedge CLK);
  endclocking
  default disable iff (!ARST_N);
  sequence s_sel_out;
    ctl_wr && WDATA[3];
  endsequence
  sequence s_flags_read;
    ADDR == 8'hF8 && !WR ##1 RDATA[7:4] != 4'h0;
  endsequence
  property p_sel_out;
    s_sel_out |=> ##1 (!NSS_OE_N && NSS_O == $past(WDATA[2], 2));
  endproperty
  a_sel_out: assert property (p_sel_out) else $error("select out wrong");
  property p_sck_half;
    sck_chg && !SCK_OE_N && master_enable |-> half >= {1'b0, div} + 9'h001;
  endproperty
  a_sck_half: assert property (p_sck_half) else $error("clock half too short");
  property p_fault_off;
    fault_cond |-> ##[1:8] (SCK_OE_N && MOSI_OE_N);
  endproperty
  a_fault_off: assert property (p_fault_off) else $error("fault left port on");
  property p_fault_irq;
    fault_cond |-> ##[1:8] IRQ;
  endproperty
  a_fault_irq: assert property (p_fault_irq) else $error("fault without irq");
  property p_unmapped;
    !(ADDR inside {8'h9A, 8'h9B, 8'h9D, 8'hF8}) |=> RDATA == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read nonzero");
  property p_raw_sel;
    ADDR == 8'h9A |=> RDATA[2] == $past(NSS_I);
  endproperty
  a_raw_sel: assert property (p_raw_sel) else $error("raw select wrong");
  property p_busy;
    $rose(SCK_O) && !pol && ADDR == 8'h9A |=> RDATA[7];
  endproperty
  a_busy: assert property (p_busy) else $error("busy low in frame");
  property p_irq;
    s_flags_read |-> IRQ;
  endproperty
  a_irq: assert property (p_irq) else $error("flag set, irq low");
endmodule : ssp_port_sva
bind ssp_port ssp_port_sva ssp_port_sva_i (.*);

// ==== test/ssp_slave_model.sv ====
// Far-end slave: clock phase 0, polarity 0, bytes most significant first
`timescale 1ns/1ps
module ssp_slave_model (
  input wire logic SCK,
  input wire logic MOSI,
  input wire logic LOAD,
  input wire logic [7:0] TX,
  output logic MISO,
  output logic [7:0] RX
);
  logic [7:0] sh;
  always @(posedge LOAD) sh = TX;
  always @(posedge SCK) RX = {RX[6:0], MOSI};
  // Spent bits refill inverted so a stale level never looks valid
  always @(negedge SCK) sh = {sh[6:0], ~sh[0]};
  assign MISO = sh[7];
  // Passive far end: it never drives the clock, so slave rate limits are kept
endmodule : ssp_slave_model

// ==== test/ssp_port_bench.sv ====
// Bench: port as master against the slave model, through register accesses
`timescale 1ns/1ps
module ssp_port_bench;
  import ssp_pkg::*;
  logic CLK = 0;
  logic ARST_N = 0;
  logic [7:0] ADDR = 8'h00;
  logic WR = 0;
  logic RD = 0;
  ssp_byte_t WDATA = 8'h00;
  ssp_byte_t RDATA;
  logic IRQ, SCK_O, SCK_OE_N, MOSI_O, MOSI_OE_N, MISO_O, MISO_OE_N, NSS_O, NSS_OE_N;
  logic miso_s, load = 0, nss_drv = 1;
  logic [7:0] tx_s = 8'h3C;
  logic [7:0] rx_s;
  int failures = 0;
  int checks_done = 0;
  // Released SCK and MOSI pulled low, released MISO driven by the slave model, select by nss_drv
  wire sck_w = SCK_OE_N ? 1'b0 : SCK_O;
  wire mosi_w = MOSI_OE_N ? 1'b0 : MOSI_O;
  wire miso_w = MISO_OE_N ? miso_s : MISO_O;
  wire nss_w = NSS_OE_N ? nss_drv : NSS_O;
  always #50 CLK = ~CLK;
  ssp_port ssp_port_i (.CLK(CLK), .ARST_N(ARST_N), .ADDR(ADDR), .WR(WR), .RD(RD),
    .WDATA(WDATA), .RDATA(RDATA), .IRQ(IRQ), .SCK_O(SCK_O), .SCK_OE_N(SCK_OE_N),
    .SCK_I(sck_w), .MOSI_O(MOSI_O), .MOSI_OE_N(MOSI_OE_N), .MOSI_I(mosi_w),
    .MISO_O(MISO_O), .MISO_OE_N(MISO_OE_N), .MISO_I(miso_w), .NSS_O(NSS_O),
    .NSS_OE_N(NSS_OE_N), .NSS_I(nss_w));
  ssp_slave_model ssp_slave_model_i (.SCK(sck_w), .MOSI(mosi_w), .LOAD(load), .TX(tx_s),
    .MISO(miso_s), .RX(rx_s));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge CLK);
    ADDR = a;
    WDATA = d;
    WR = 1;
    @(negedge CLK);
    WR = 0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge CLK);
    ADDR = a;
    RD = 1;
    @(negedge CLK);
    RD = 0;
    chk(RDATA, e);
  endtask : rd
  task automatic summarize;
    $display("checks=%0d failures=%0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : summarize
  initial begin
    repeat (5) @(negedge CLK);
    ARST_N = 1;
    rd(8'h9B, 8'h00);
    rd(8'h9D, 8'h00);
    rd(8'hF8, 8'h06);
    rd(8'h9A, 8'h07);
    rd(8'h55, 8'h00);
    load = 1;
    wr(8'h9D, 8'h02);
    wr(8'h9A, 8'h40);
    wr(8'hF8, 8'h01);
    wr(8'h9B, 8'hA5);
    wr(8'h9B, 8'h5A);
    rd(8'h9A, 8'hC7);
    repeat (50) @(negedge CLK);
    rd(8'hF8, 8'hC3);
    rd(8'h9B, 8'h3C);
    chk(rx_s, 8'hA5);
    wr(8'hF8, 8'h01);
    rd(8'hF8, 8'h03);
    chk({7'h00, IRQ}, 8'h00);
    wr(8'hF8, 8'h09);
    repeat (2) @(negedge CLK);
    chk({6'h00, NSS_OE_N, NSS_O}, 8'h00);
    wr(8'hF8, 8'h0D);
    repeat (2) @(negedge CLK);
    chk({6'h00, NSS_OE_N, NSS_O}, 8'h01);
    wr(8'hF8, 8'h00);
    wr(8'h9A, 8'h50);
    wr(8'hF8, 8'h01);
    repeat (2) @(negedge CLK);
    chk({7'h00, SCK_O}, 8'h01);
    wr(8'hF8, 8'h00);
    wr(8'h9A, 8'h40);
    wr(8'hF8, 8'h05);
    nss_drv = 0;
    repeat (10) @(negedge CLK);
    rd(8'hF8, 8'h26);
    rd(8'h9A, 8'h0B);
    chk({7'h00, IRQ}, 8'h01);
    chk({6'h00, MISO_OE_N, MISO_O}, 8'h02);
    summarize();
  end
  initial begin
    repeat (3000) @(posedge CLK);
    failures++;
    summarize();
  end
endmodule : ssp_port_bench
